// >>> rtl/crosspoint_parallel_loader.v
// Crosspoint parallel loader: pins, two register ranks, APB view
`timescale 1ns/1ps
`include "xpt_regs.vh"
module crosspoint_parallel_loader (
	// APB
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Parallel pins
	input wire interface_mode_select,
	input wire [2:0] output_buffer_select,
	input wire [3:0] input_or_command_code,
	input wire wr_strobe,
	input wire latch_strobe,
	input wire edge_level_sel,
	input wire chip_en,
	input wire chip_en_n,
	// Switch state
	output reg [31:0] route_out,
	output reg [7:0] buf_on_out
);
	wire mode_s;
	wire wr_s;
	wire lat_s;
	wire edge_s;
	wire ce_s;
	wire cen_s;
	wire [2:0] sel_s;
	wire [3:0] code_s;
	wire [6:0] word_s;
	wire wr_pin_rise, lat_pin_rise, lat_pin_low;
	wire wr_gate, wr_rise, lat_rise, lat_low;
	wire apb_wr, apb_rd;
	reg [7:0] ctrl_r;
	reg [3:0] rank1_r [0:7];
	reg [3:0] rank2_r [0:7];
	reg [7:0] bon_r;
	reg [7:0] bon_nxt;
	reg soft_lat_r;
	reg [7:0] wr_count_r;
	reg [31:0] rank1_flat;
	reg [31:0] rank2_flat;
	wire [6:0] word_pin;
	wire wr_act;
	wire lat_fire;
	reg store_en;
	reg soft_req;
	reg off_one;
	reg on_one;
	reg off_all;
	reg on_all;
	integer i;
	integer j;
	integer k;

	// Every pin passes two flops before use
	sync2 u_s_mode (.pclk(pclk), .presetn(presetn), .d(interface_mode_select), .q(mode_s));
	sync2 u_s_wr (.pclk(pclk), .presetn(presetn), .d(wr_strobe), .q(wr_s));
	sync2 u_s_lat (.pclk(pclk), .presetn(presetn), .d(latch_strobe), .q(lat_s));
	sync2 u_s_edge (.pclk(pclk), .presetn(presetn), .d(edge_level_sel), .q(edge_s));
	sync2 u_s_ce (.pclk(pclk), .presetn(presetn), .d(chip_en), .q(ce_s));
	sync2 u_s_cen (.pclk(pclk), .presetn(presetn), .d(chip_en_n), .q(cen_s));
	assign word_pin = {output_buffer_select, input_or_command_code}; // RULE1
	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1)
		begin : g_dat
			sync2 u_s_d (.pclk(pclk), .presetn(presetn),
				.d(word_pin[g]), .q(word_s[g]));
		end
	endgenerate
	assign code_s = word_s[3:0]; // RULE7
	assign sel_s = word_s[6:4]; // RULE1

	// Software can also drive the strobes and chip_en, ORed with the pins; chip_en_n gates only while its control bit is set
	assign wr_gate = (wr_s | ctrl_r[`XPT_CTRL_WR_BIT]) & (ce_s | ctrl_r[`XPT_CTRL_CE_BIT])
		& ~(cen_s & ctrl_r[`XPT_CTRL_CEN_BIT]); // RULE10
	rise_det u_wr (.pclk(pclk), .presetn(presetn), .lvl(wr_gate), .rise(wr_rise), .low());
	rise_det u_lat (.pclk(pclk), .presetn(presetn),
		.lvl(lat_s | ctrl_r[`XPT_CTRL_LATCH_BIT]), .rise(lat_rise), .low(lat_low));
	assign wr_pin_rise = wr_rise;
	assign lat_pin_rise = lat_rise;
	assign lat_pin_low = lat_low;

	// APB: zero wait states, unmapped offsets read zero without error
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & ~penable & ~pwrite;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_r <= `XPT_CTRL_RST;
		else if (apb_wr && paddr == `XPT_CTRL_OFF)
			ctrl_r <= pwdata[7:0];
	end

	always @*
	begin
		rank1_flat = 32'h0;
		rank2_flat = 32'h0;
		for (i = 0; i < 8; i = i + 1)
		begin
			rank1_flat[i*4 +: 4] = rank1_r[i];
			rank2_flat[i*4 +: 4] = rank2_r[i];
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (apb_rd)
		begin
			case (paddr)
				`XPT_CTRL_OFF: prdata <= {24'h0, ctrl_r};
				`XPT_STAT_OFF: prdata <= {15'h0, mode_s, wr_count_r, bon_r};
				`XPT_ROUTE_OFF: prdata <= rank2_flat;
				`XPT_SHADOW_OFF: prdata <= rank1_flat;
				default: prdata <= 32'h0;
			endcase
		end
	end

	// A word acts only in parallel mode; serial mode is not built
	assign wr_act = wr_pin_rise & ~mode_s;
	// Level mode copies on every clock while the strobe is low
	assign lat_fire = (edge_s & lat_pin_rise) | (~edge_s & lat_pin_low) | soft_lat_r; // RULE9

	// Word decode: one flag per action, defaults keep every path assigned
	always @*
	begin
		store_en = 1'b0;
		soft_req = 1'b0;
		off_one = 1'b0;
		on_one = 1'b0;
		off_all = 1'b0;
		on_all = 1'b0;
		case (code_s)
			4'h0:
			begin
				store_en = 1'b1; // RULE8
			end
			4'h1:
			begin
				store_en = 1'b1; // RULE8
			end
			4'h2:
			begin
				store_en = 1'b1; // RULE8
			end
			4'h3:
			begin
				store_en = 1'b1; // RULE8
			end
			4'h4:
			begin
				store_en = 1'b1; // RULE8
			end
			4'h5:
			begin
				store_en = 1'b1; // RULE8
			end
			4'h6:
			begin
				store_en = 1'b1; // RULE8
			end
			4'h7:
			begin
				store_en = 1'b1; // RULE8
			end
			`XPT_CODE_GND:
			begin
				store_en = 1'b1; // RULE8
			end
			`XPT_CODE_SER_A:
			begin
				store_en = 1'b0; // RULE12
			end
			`XPT_CODE_SER_B:
			begin
				store_en = 1'b0; // RULE12
			end
			`XPT_CODE_OFF1:
			begin
				off_one = 1'b1; // RULE8
			end
			`XPT_CODE_ON1:
			begin
				on_one = 1'b1; // RULE8
			end
			`XPT_CODE_OFFALL:
			begin
				off_all = 1'b1; // RULE8
			end
			`XPT_CODE_ONALL:
			begin
				on_all = 1'b1; // RULE8
			end
			`XPT_CODE_SOFTLAT:
			begin
				soft_req = 1'b1; // RULE8
			end
			default:
			begin
				store_en = 1'b0;
			end
		endcase
	end

	// Buffer enables act on the live state, second rank kept
	always @*
	begin
		bon_nxt = bon_r;
		if (wr_act)
		begin
			if (off_all)
				bon_nxt = 8'h00; // RULE8
			else if (on_all)
				bon_nxt = 8'hff; // RULE8
			else if (off_one)
				bon_nxt[sel_s] = 1'b0; // RULE8
			else if (on_one)
				bon_nxt[sel_s] = 1'b1; // RULE8
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bon_r <= 8'h00; // RULE11
		else
			bon_r <= bon_nxt;
	end

	// Count of accepted words, readable for software
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wr_count_r <= 8'h00;
		else if (wr_act)
			wr_count_r <= wr_count_r + 8'h01;
	end

	// Copy lags the soft-transfer word by a cycle; that word is not stored, so the copy takes earlier words
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			soft_lat_r <= 1'b0;
		else
			soft_lat_r <= wr_act & soft_req; // RULE8
	end

	// Codes above ground leave the first rank alone
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (j = 0; j < 8; j = j + 1)
				rank1_r[j] <= `XPT_SEL_RST;
		end
		else if (wr_act && store_en)
			rank1_r[sel_s] <= code_s; // RULE2 RULE4
	end

	// All route outputs switch together from one copy
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (k = 0; k < 8; k = k + 1)
				rank2_r[k] <= `XPT_SEL_RST;
		end
		else if (lat_fire)
		begin
			// Whole rank at once, never output by output
			for (k = 0; k < 8; k = k + 1)
				rank2_r[k] <= rank1_r[k]; // RULE3
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			route_out <= {8{`XPT_SEL_RST}};
			buf_on_out <= 8'h00;
		end
		else
		begin
			route_out <= rank2_flat;
			buf_on_out <= bon_r;
		end
	end
endmodule // crosspoint_parallel_loader

// >>> rtl/rise_det.v
// Rising-edge pulse detector on a synchronised level
`timescale 1ns/1ps
module rise_det (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Level in, rise pulse and low level out
	input wire lvl,
	output wire rise,
	output wire low
);
	reg prev_r;
	always @(posedge pclk or negedge presetn)
	begin
		// Reset high: a level already up after reset is not taken as an edge
		if (!presetn)
			prev_r <= 1'b1;
		else
			prev_r <= lvl;
	end
	assign rise = lvl & ~prev_r;
	assign low = ~lvl;
endmodule // rise_det

// >>> rtl/sync2.v
// Two-stage synchroniser for one pin
`timescale 1ns/1ps
module sync2 (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Data
	input wire d,
	output reg q
);
	reg meta_r;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_r <= 1'b0;
			q <= 1'b0;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // sync2

// >>> rtl/xpt_regs.vh
// Constants for the crosspoint parallel loader
// What this block does
// RULE1: Seven data lines plus write and transfer strobes
// RULE2: Write strobe rise captures word into first rank
// RULE3: Transfer rise copies first rank to second
// RULE4: Each route or ground word (codes 0-8) changes exactly one output entry
// RULE5: Host writes several words, then one transfer
// RULE6: Host drives chip enables and load lines
// RULE7: Word is buffer times sixteen plus code
// RULE8: Codes route, ground, enable, disable, soft transfer
// RULE9: Level mode: second rank follows while strobe low
// RULE10: Write strobe gated by both chip enables (code: chip_en gates only with ctrl bit 3 clear, chip_en_n only with bit 4 set)
// RULE11: All buffers disabled after reset
// RULE12: Serial-only codes ignored in parallel mode
`ifndef XPT_REGS_VH
`define XPT_REGS_VH
`define XPT_CTRL_OFF 12'h000
`define XPT_STAT_OFF 12'h004
`define XPT_ROUTE_OFF 12'h008
`define XPT_SHADOW_OFF 12'h00c
`define XPT_CTRL_WR_BIT 0
`define XPT_CTRL_LATCH_BIT 1
`define XPT_CTRL_EDGE_BIT 2
`define XPT_CTRL_CE_BIT 3
`define XPT_CTRL_CEN_BIT 4
`define XPT_CTRL_RST 8'h0d
`define XPT_CODE_GND 4'h8
`define XPT_CODE_SER_A 4'h9
`define XPT_CODE_SER_B 4'ha
`define XPT_CODE_OFF1 4'hb
`define XPT_CODE_ON1 4'hc
`define XPT_CODE_OFFALL 4'hd
`define XPT_CODE_ONALL 4'he
`define XPT_CODE_SOFTLAT 4'hf
`define XPT_SEL_RST 4'h8
`endif

// >>> tb/host_port.sv
// Host parallel port model driving word and strobe pins
`timescale 1ns/1ps
module host_port (
	// Clock
	input wire pclk,
	// Pins
	output logic interface_mode_select,
	output logic [2:0] output_buffer_select,
	output logic [3:0] input_or_command_code,
	output logic wr_strobe,
	output logic latch_strobe
);
	initial {interface_mode_select, output_buffer_select, input_or_command_code} = 8'h00;
	initial {wr_strobe, latch_strobe} = 2'b00;
	// Word is buffer times sixteen plus code, held well past the strobe
	task automatic send(input logic [6:0] word);
		@(posedge pclk);
		{output_buffer_select, input_or_command_code} <= word;
		repeat (5) @(posedge pclk);
		wr_strobe <= 1'b1;
		repeat (5) @(posedge pclk);
		wr_strobe <= 1'b0;
		repeat (5) @(posedge pclk);
	endtask
	task automatic set_mode(input logic m);
		@(posedge pclk);
		interface_mode_select <= m;
	endtask
	task automatic latch();
		@(posedge pclk);
		latch_strobe <= 1'b1;
		repeat (5) @(posedge pclk);
		latch_strobe <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask
endmodule // host_port

// >>> tb/tb_crosspoint_parallel_loader.sv
// Self-checking bench for the crosspoint parallel loader
`timescale 1ns/1ps
module tb_crosspoint_parallel_loader;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	logic edge_level_sel = 1, chip_en = 1, chip_en_n = 0;
	wire [31:0] prdata, route_out;
	wire [7:0] buf_on_out;
	wire pready, pslverr, interface_mode_select, wr_strobe, latch_strobe;
	wire [2:0] output_buffer_select;
	wire [3:0] input_or_command_code;
	int bad_count = 0, total_checks = 0, cycles = 0;
	logic [14:0] seq[5] = '{{8'h08, 7'h3c}, {8'hff, 7'h0e}, {8'hdf, 7'h5b}, 15'h000d, 15'h0029};
	logic [1:0] ce_tab[3] = '{2'b00, 2'b11, 2'b10};
	always #4 pclk = ~pclk;
	host_port i_host (.*);
	crosspoint_parallel_loader i_dut (.*);
	task automatic check(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		{psel, penable} <= 2'b00;
		@(posedge pclk);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("route", route_out, 32'h88888888);
		check("bufs", buf_on_out, 8'h00);
		apb(0, 12'h000, 0);
		check("ctrl", rd, 32'h0d);
		apb(1, 12'h000, 32'h08);
		apb(0, 12'h100, 0);
		check("unmapped", rd, 0);
		i_host.send(7'h35);
		check("rank2 held", route_out, 32'h88888888);
		i_host.send(7'h62);
		i_host.latch();
		check("route", route_out, 32'h82885888);
		apb(0, 12'h008, 0);
		check("rank2 reg", rd, 32'h82885888);
		foreach (seq[i])
		begin
			i_host.send(seq[i][6:0]);
			check("bufs", buf_on_out, seq[i][14:7]);
		end
		i_host.latch();
		check("route", route_out, 32'h82885888);
		i_host.send(7'h10);
		i_host.send(7'h0f);
		check("soft latch", route_out, 32'h82885808);
		apb(1, 12'h000, 32'h10);
		for (int i = 0; i < 3; i++)
		begin
			{chip_en, chip_en_n} <= ce_tab[i];
			i_host.send(7'h41);
			i_host.latch();
			check("gated", route_out, i == 2 ? 32'h82815808 : 32'h82885808);
		end
		i_host.set_mode(1'b1);
		i_host.send(7'h04);
		i_host.latch();
		check("serial ignored", route_out, 32'h82815808);
		i_host.set_mode(1'b0);
		edge_level_sel <= 1'b0;
		i_host.send(7'h73);
		check("level", route_out, 32'h32815808);
		give_verdict();
	end
endmodule // tb_crosspoint_parallel_loader

// >>> tb/xpt_assertions.sv
// Checker for the crosspoint parallel loader ports
`timescale 1ns/1ps
module xpt_checker (
	// Clock, reset, bus answer
	input wire pclk,
	input wire presetn,
	input wire pready,
	input wire pslverr,
	// Pins
	input wire wr_strobe,
	input wire latch_strobe,
	input wire edge_level_sel,
	input wire [2:0] output_buffer_select,
	input wire [3:0] input_or_command_code,
	// Switch state
	input wire [31:0] route_out,
	input wire [7:0] buf_on_out
);
	wire [3:0] cd = input_or_command_code;
	wire [2:0] bs = output_buffer_select;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_ok_a: assert property (pready && !pslverr) else $error("apb answer");
	reset_state_a: assert property ($rose(presetn) |-> route_out == 32'h88888888 && buf_on_out == 8'h00) else $error("reset");
	route_hold_a: assert property (
		(edge_level_sel && $stable(latch_strobe) && $stable(wr_strobe))[*8] |-> $stable(route_out))
		else $error("route moved");
	buf_hold_a: assert property ($stable(wr_strobe)[*8] |-> $stable(buf_on_out)) else $error("buf moved");
	serial_code_a: assert property (($rose(wr_strobe) && cd inside {4'h9, 4'ha}) |=> $stable(buf_on_out)[*6]) else $error("code 9/a");
	level_follow_a: assert property (
		($rose(wr_strobe) && !edge_level_sel && !latch_strobe && cd < 4'h9)
		|-> ##8 route_out[bs*4 +: 4] == $past(cd, 8)) else $error("level");
	buf_one_a: assert property (($rose(wr_strobe) && cd == 4'hc) |-> ##8 buf_on_out[bs]) else $error("on");
	all_off_a: assert property (($rose(wr_strobe) && cd == 4'hd) |-> ##8 buf_on_out == 8'h00) else $error("off");
endmodule // xpt_checker
bind crosspoint_parallel_loader xpt_checker i_chk (.*);
